// ### core/sfpp_top.sv
/*
 serial flash programming port: mode straps, four-wire link, id check gate and area protection.
 assumes the flash array answers requests by raising a done pulse; sclk from the programmer only.
*/
`timescale 1ns/1ps
`include "sfpp_consts.svh"
module sfpp_top (
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic CLK_EN,
   input wire logic PORT5_LINE0,
   input wire logic PROGRAM_MODE_SELECT_PIN,
   input wire logic PROCESSOR_MODE_PIN,
   input wire logic PARALLEL_MODE,
   input wire logic TRANSFER_CLOCK_PIN,
   input wire logic SERIAL_DATA_INPUT,
   output logic SERIAL_DATA_OUTPUT,
   output logic BUSY_FLAG_OUTPUT,
   input wire logic FLASH_BLANK,
   input wire logic [55:0] STORED_ID,
   input wire logic BOOT_PROGRAM_OK,
   input wire logic [23:0] PAR_ADDR,
   input wire logic PAR_PROG,
   input wire logic PAR_ERASE,
   output sfpp_pkg::sfpp_req_t FLASH_REQ,
   input wire logic FLASH_DONE,
   input wire logic [7:0] STATUS_BYTE,
   output logic SERIAL_MODE,
   output logic ID_OK,
   output logic BOOT_TOUCHED
);
   import sfpp_pkg::*;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // boot window test used by both parallel and serial paths
   function automatic logic in_boot(input logic [23:0] a);
      in_boot = (a >= `SFPP_BOOT_LO) && (a <= `SFPP_BOOT_HI);
   endfunction
   // ----------------------------------------------------------------
   // pin synchronisers and reset counter
   // ----------------------------------------------------------------
   logic [2:0] strap_s1_r, strap_s2_r;   // strap pins, two flops
   logic [2:0] tog_s_r;                  // byte toggle: two sync stages plus history
   logic [4:0] rst_cnt_r;                // mclk edges seen while reset held
   logic rst_ok_r;                       // reset was long enough
   logic rst_d_r;                        // reset delayed, finds the release
   sfpp_strap_t strap_r;                 // straps caught at release
   sfpp_byte_t rxb;                      // byte from the link domain
   logic [7:0] tx_r;                     // byte offered to the link
   wire strap_rel = rst_d_r & ~SYS_RST;
   wire new_byte = tog_s_r[2] ^ tog_s_r[1];
   // two flops before any logic reads the strap pins
   always_ff @(posedge MCLK) begin
      if (CLK_EN) begin
         strap_s1_r <= {PORT5_LINE0, PROGRAM_MODE_SELECT_PIN, PROCESSOR_MODE_PIN};
         strap_s2_r <= strap_s1_r;
         tog_s_r <= {tog_s_r[1:0], rxb.tog};
         rst_d_r <= SYS_RST;
      end
   end
   // count main clock cycles during reset; short resets leave the port quiet
   always_ff @(posedge MCLK) begin
      if (CLK_EN) begin
         if (SYS_RST) begin
            if (rst_cnt_r != 5'(`SFPP_RST_CYCLES)) begin
               rst_cnt_r <= rst_cnt_r + 5'h01;
            end
         end else begin
            rst_cnt_r <= 5'h00;
         end
      end
   end
   // straps sampled by a clocked process at the release edge
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         rst_ok_r <= 1'b0;
         strap_r <= '0;
      end else if (CLK_EN && strap_rel) begin
         rst_ok_r <= (rst_cnt_r == 5'(`SFPP_RST_CYCLES));
         strap_r <= strap_s2_r;
      end
   end
   // serial mode needs the straps, a full reset and an intact boot program
   wire serial_on = strap_r.serial_sel & ~strap_r.prog_sel & strap_r.proc_mode
                    & rst_ok_r & BOOT_PROGRAM_OK;
   // ----------------------------------------------------------------
   // link instance on the transfer clock
   // ----------------------------------------------------------------
   sfpp_link u_link (
      .sclk(TRANSFER_CLOCK_PIN),
      .rxd(SERIAL_DATA_INPUT),
      .tx_byte(tx_r),
      .rx_out(rxb),
      .txd(SERIAL_DATA_OUTPUT)
   );
   // ----------------------------------------------------------------
   // command sequencer
   // ----------------------------------------------------------------
   sfpp_state_t st_r, st_nxt;
   logic [7:0] cmd_r;          // current command byte
   logic [23:0] addr_r;        // page or block address
   logic [2:0] idn_r;          // id bytes received
   logic id_ok_r;              // id matched
   logic id_bad_r;             // some id byte differed
   logic busy_r;               // flash operation in flight
   logic boot_hit_r;           // parallel write reached the boot area
   logic [7:0] pcnt_r;         // page byte counter
   sfpp_req_t req_r;
   // id byte picked by index, first byte in the low lane
   wire [7:0] id_exp = STORED_ID[{idn_r, 3'h0} +: 8];
   wire cmd_open = FLASH_BLANK | id_ok_r;
   wire cmd_any = (rxb.data == `SFPP_CMD_IDCHK) | (rxb.data == `SFPP_CMD_STAT)
                  | (rxb.data == `SFPP_CMD_VER) | cmd_open;
   wire user_addr = ~in_boot(addr_r);
   wire page_end = (pcnt_r == 8'hff);
   wire idle = (st_r == SFPP_IDLE);
   // next state from the received byte
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         SFPP_IDLE: begin
            if (new_byte && cmd_any && rxb.data == `SFPP_CMD_IDCHK) begin
               st_nxt = SFPP_IDCK;
            end else if (new_byte && cmd_any && (rxb.data == `SFPP_CMD_PROG || rxb.data == `SFPP_CMD_ERASE)) begin
               st_nxt = SFPP_AMID;
            end
         end
         SFPP_AMID: if (new_byte) st_nxt = SFPP_AHIGH;
         SFPP_AHIGH: if (new_byte) st_nxt = (cmd_r == `SFPP_CMD_ERASE) ? SFPP_CONF : SFPP_DATA;
         SFPP_DATA: if (new_byte && page_end) st_nxt = SFPP_IDLE;
         SFPP_CONF: if (new_byte) st_nxt = SFPP_IDLE;
         SFPP_IDCK: if (new_byte && idn_r == `SFPP_ID_BYTES - 3'h1) st_nxt = SFPP_IDLE;
      endcase
   end
   // sequencer registers; address is middle then high byte
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         st_r <= SFPP_IDLE;
         cmd_r <= 8'h00;
         addr_r <= 24'h000000;
         idn_r <= 3'h0;
         id_ok_r <= 1'b0;
         id_bad_r <= 1'b0;
         pcnt_r <= 8'h00;
      end else if (CLK_EN && serial_on) begin
         st_r <= st_nxt;
         if (new_byte) begin
            unique case (st_r)
               SFPP_IDLE: begin
                  cmd_r <= rxb.data;
                  idn_r <= 3'h0;
                  pcnt_r <= 8'h00;
               end
               SFPP_AMID: addr_r <= {8'h00, rxb.data, 8'h00};
               SFPP_AHIGH: addr_r[23:16] <= rxb.data;
               SFPP_DATA: pcnt_r <= pcnt_r + 8'h01;
               SFPP_CONF: ;
               SFPP_IDCK: begin
                  // first four bytes are address and size, then seven id bytes
                  if (idn_r == 3'h0 && pcnt_r != 8'h04) begin
                     pcnt_r <= pcnt_r + 8'h01;
                     id_bad_r <= 1'b0;
                  end else begin
                     if (rxb.data != id_exp) id_bad_r <= 1'b1;
                     idn_r <= idn_r + 3'h1;
                     if (idn_r == `SFPP_ID_BYTES - 3'h1) begin
                        id_ok_r <= ~id_bad_r & (rxb.data == id_exp);
                     end
                  end
               end
            endcase
         end
      end
   end
   // ----------------------------------------------------------------
   // flash requests and area protection
   // ----------------------------------------------------------------
   wire ser_prog = new_byte && st_r == SFPP_DATA && user_addr;
   wire ser_erase = new_byte && st_r == SFPP_CONF && rxb.data == `SFPP_CONFIRM && user_addr;
   wire par_boot = in_boot(PAR_ADDR);
   // boot erase in parallel mode clears the whole block from its base
   wire [23:0] par_addr = (PAR_ERASE && par_boot) ? `SFPP_BOOT_LO : PAR_ADDR;
   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         req_r <= '0;
         busy_r <= 1'b0;
         boot_hit_r <= 1'b0;
         tx_r <= 8'h00;
      end else if (CLK_EN) begin
         req_r.prog <= 1'b0;
         req_r.erase <= 1'b0;
         if (PARALLEL_MODE && (PAR_PROG || PAR_ERASE)) begin
            req_r <= '{prog: PAR_PROG, erase: PAR_ERASE, addr: par_addr, data: 8'h00};
            busy_r <= 1'b1;
            if (par_boot) boot_hit_r <= 1'b1;
         end else if (serial_on && (ser_prog || ser_erase)) begin
            req_r <= '{prog: ser_prog, erase: ser_erase, addr: {addr_r[23:8], pcnt_r}, data: rxb.data};
            busy_r <= 1'b1;
         end else if (FLASH_DONE) begin
            busy_r <= 1'b0;
         end
         if (idle) tx_r <= STATUS_BYTE;   // status offered for the next outbound unit
      end
   end
   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // busy rises for the byte seen and while flash works; only synced toggle
   // stages feed it, so the programmer's gap has to cover the sync lag
   wire rx_active = new_byte;
   assign BUSY_FLAG_OUTPUT = ~serial_on | busy_r | rx_active;
   assign FLASH_REQ = req_r;
   assign SERIAL_MODE = serial_on;
   assign ID_OK = id_ok_r;
   assign BOOT_TOUCHED = boot_hit_r;
endmodule // sfpp_top

// ### core/sfpp_consts.svh
/*
 constants for the serial flash programming port: command bytes, boot window, id check sizes, timing counts.
 assumes inclusion by bare name from the package and modules of this block.
*/
`ifndef SFPP_CONSTS_SVH
`define SFPP_CONSTS_SVH
// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define SFPP_BOOT_LO 24'h0fe000
`define SFPP_BOOT_HI 24'h0fffff
`define SFPP_BOOT_BYTES 32'h00002000
// ----------------------------------------------------------------
// command bytes and id check
// ----------------------------------------------------------------
`define SFPP_CMD_PROG 8'h41
`define SFPP_CMD_ERASE 8'h20
`define SFPP_CMD_IDCHK 8'hf5
`define SFPP_CMD_STAT 8'h70
`define SFPP_CMD_VER 8'hfb
`define SFPP_CONFIRM 8'hd0
`define SFPP_ID_BYTES 3'h7
`define SFPP_UNIT_BITS 3'h7
// ----------------------------------------------------------------
// timing: reset clock cycles, in mclk cycles at 40 mhz
// ----------------------------------------------------------------
`define SFPP_MCLK_MHZ 40
`define SFPP_RST_CYCLES 20
`endif

// ### core/sfpp_pkg.sv
/*
 types of the serial flash programming port.
 assumes the constants header is on the include path.
*/
package sfpp_pkg;
`include "sfpp_consts.svh"
   // ----------------------------------------------------------------
   // mode straps caught at reset release
   // ----------------------------------------------------------------
   typedef struct packed {
      logic serial_sel;    // port5_line0 level
      logic prog_sel;      // program_mode_select_pin level
      logic proc_mode;     // processor_mode_pin level
   } sfpp_strap_t;
   // one received byte crossing to the core domain
   typedef struct packed {
      logic [7:0] data;
      logic tog;
   } sfpp_byte_t;
   // flash request toward the array
   typedef struct packed {
      logic prog;
      logic erase;
      logic [23:0] addr;
      logic [7:0] data;
   } sfpp_req_t;
   typedef enum logic [5:0] {
      SFPP_IDLE  = 6'h01,
      SFPP_AMID  = 6'h02,
      SFPP_AHIGH = 6'h04,
      SFPP_DATA  = 6'h08,
      SFPP_IDCK  = 6'h10,
      SFPP_CONF  = 6'h20
   } sfpp_state_t;
endpackage

// ### core/sfpp_link.sv
/*
 link side of the serial port: shifts bytes in on rising sclk, out lsb first on falling sclk.
 assumes sclk comes only from the external programmer and stands still between bytes.
*/
`timescale 1ns/1ps
`include "sfpp_consts.svh"
module sfpp_link (
   input wire logic sclk,
   input wire logic rxd,
   input wire logic [7:0] tx_byte,
   output sfpp_pkg::sfpp_byte_t rx_out,
   output logic txd
);
   import sfpp_pkg::*;
   // ----------------------------------------------------------------
   // receive shifter
   // ----------------------------------------------------------------
   logic [6:0] sh_r = 7'h00;    // partial byte, lsb first
   logic [2:0] cnt_r = 3'h0;    // bit count within the unit
   logic tog_r = 1'b0;          // flips once per whole byte
   logic [7:0] data_r = 8'h00;  // last whole byte, stable for crossing
   logic [7:0] txs_r = 8'h00;   // transmit shifter
   wire last_bit = (cnt_r == `SFPP_UNIT_BITS);
   wire [7:0] full_byte = {rxd, sh_r};
   // sample data on each rising transfer clock edge
   always_ff @(posedge sclk) begin
      sh_r <= {rxd, sh_r[6:1]};
      cnt_r <= cnt_r + 3'h1;
      if (last_bit) begin
         data_r <= full_byte;
         tog_r <= ~tog_r;                   // toggle marks one byte for the core
      end
   end
   // transmit changes only on falling edges; the word is loaded after the last bit of a unit
   always_ff @(negedge sclk) begin
      if (cnt_r == 3'h0) begin
         txs_r <= tx_byte;
      end else begin
         txs_r <= {1'b0, txs_r[7:1]};
      end
   end
   // tx_byte is held stable by the core while idle, so no sync here;
   // bit 0 of the next unit already stands before its first rising edge
   assign txd = txs_r[0];
   assign rx_out = '{data: data_r, tog: tog_r};
endmodule // sfpp_link

// ### sim/sfpp_prog_model.sv
/*
 programmer model: makes the transfer clock, shifts bytes in, reads the answer.
 assumes busy comes from the device busy flag output.
*/
`timescale 1ns/1ps
module sfpp_prog_model (
   input wire logic busy,
   input wire logic txd,
   output logic sclk,
   output logic rxd
);
   // clock stands still low between bytes, only this side drives it
   initial begin
      sclk = 1'b0;
      rxd = 1'b1;
   end
   // one unit, lsb first; the gap lets busy rise before it is polled
   task automatic xfer(input logic [7:0] b, input int gap, output logic [7:0] got);
      int n;
      n = 0;
      #(gap);
      while (busy !== 1'b0 && n < 4000) begin
         #8;
         n++;
      end
      for (int i = 0; i < 8; i++) begin
         rxd = b[i];
         #32 sclk = 1'b1;
         got[i] = txd;
         #32 sclk = 1'b0;
      end
      rxd = ~b[7]; // released line never shows the stale bit
   endtask
endmodule // sfpp_prog_model

// ### sim/sfpp_top_sva.sv
/*
 pin assertions of the programming port.
 assumes binding onto sfpp_top, main clock domain only.
*/
`timescale 1ns/1ps
`include "sfpp_consts.svh"
module sfpp_top_sva (
   input wire logic MCLK,
   input wire logic SYS_RST,
   input wire logic PARALLEL_MODE,
   input wire logic [23:0] PAR_ADDR,
   input wire logic PAR_PROG,
   input wire logic PAR_ERASE,
   input wire logic TRANSFER_CLOCK_PIN,
   input wire logic SERIAL_DATA_OUTPUT,
   input wire logic BUSY_FLAG_OUTPUT,
   input wire logic FLASH_BLANK,
   input sfpp_pkg::sfpp_req_t FLASH_REQ,
   input wire logic SERIAL_MODE,
   input wire logic ID_OK,
   input wire logic BOOT_TOUCHED
);
   import sfpp_pkg::*;
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (SYS_RST);
   wire req_any = FLASH_REQ.prog | FLASH_REQ.erase; // any request to the array
   wire boot_hit = (FLASH_REQ.addr >= `SFPP_BOOT_LO) && (FLASH_REQ.addr <= `SFPP_BOOT_HI);
   wire par_in = (PAR_ADDR >= `SFPP_BOOT_LO) && (PAR_ADDR <= `SFPP_BOOT_HI);
   wire par_hit = PARALLEL_MODE && (PAR_PROG || PAR_ERASE) && par_in;
   wire locked = SERIAL_MODE && !PARALLEL_MODE; // serial traffic only
   a_idle_busy: assert property (!SERIAL_MODE |-> BUSY_FLAG_OUTPUT)
      else $error("busy low outside serial mode");
   a_req_busy: assert property (locked && req_any |-> BUSY_FLAG_OUTPUT)
      else $error("busy low during request");
   a_req_pulse: assert property (FLASH_REQ.prog |=> !FLASH_REQ.prog)
      else $error("program request too long");
   a_user_only: assert property (locked && req_any |-> !boot_hit)
      else $error("serial request in boot area");
   a_erase_whole: assert property (FLASH_REQ.erase && boot_hit |-> FLASH_REQ.addr == `SFPP_BOOT_LO)
      else $error("partial boot erase");
   a_boot_mark: assert property (par_hit |-> ##[1:2] BOOT_TOUCHED)
      else $error("boot access not marked");
   a_id_gate: assert property (locked && !FLASH_BLANK && !$past(ID_OK) |-> !req_any)
      else $error("request without id");
   a_tx_steady: assert property (TRANSFER_CLOCK_PIN && $past(TRANSFER_CLOCK_PIN) |-> $stable(SERIAL_DATA_OUTPUT))
      else $error("output moved while clock high");
   c_prog: cover property (FLASH_REQ.prog);
   c_erase: cover property (locked && FLASH_REQ.erase);
   c_id: cover property ($rose(ID_OK));
endmodule // sfpp_top_sva
bind sfpp_top sfpp_top_sva u_sva (.MCLK, .SYS_RST, .PARALLEL_MODE, .PAR_ADDR, .PAR_PROG, .PAR_ERASE,
   .TRANSFER_CLOCK_PIN, .SERIAL_DATA_OUTPUT, .BUSY_FLAG_OUTPUT, .FLASH_BLANK, .FLASH_REQ, .SERIAL_MODE,
   .ID_OK, .BOOT_TOUCHED);

// ### sim/test_serial_flash_programming_port.sv
/*
 bench of the programming port: straps, id gate, user and boot requests.
 assumes the programmer model and checker are compiled before it.
*/
`timescale 1ns/1ps
`include "sfpp_consts.svh"
module test_serial_flash_programming_port;
   import sfpp_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] st = 3'b000; // serial, program, processor straps
   logic par_mode = 1'b0;
   logic par_erase = 1'b0;
   logic [23:0] par_addr = 24'h000000;
   logic [55:0] sid = 56'h0;
   logic [7:0] status = 8'h00;
   logic sclk, rxd, txd, busy, smode, id_ok, touched;
   logic done = 1'b0;
   logic blank = 1'b0; // flash reported blank
   logic boot_ok = 1'b1; // boot program intact
   logic par_prog = 1'b0;
   logic [4:0] dly = 5'h00; // cycles until the flash answers
   sfpp_req_t req, e;
   sfpp_req_t exp_q[$]; // requests still to come
   logic [7:0] last, mid, hi, d;
   logic [2:0] straps [4] = '{3'b100, 3'b111, 3'b001, 3'b101};
   logic [31:0] seed = 32'h000094b5;
   int fails = 0;
   int comparisons = 0;
   int cyc = 0;
   sfpp_top dut (.MCLK(mclk), .SYS_RST(rst), .CLK_EN(1'b1), .PORT5_LINE0(st[2]), .PROGRAM_MODE_SELECT_PIN(st[1]),
      .PROCESSOR_MODE_PIN(st[0]), .PARALLEL_MODE(par_mode), .TRANSFER_CLOCK_PIN(sclk), .SERIAL_DATA_INPUT(rxd),
      .SERIAL_DATA_OUTPUT(txd), .BUSY_FLAG_OUTPUT(busy), .FLASH_BLANK(blank), .STORED_ID(sid),
      .BOOT_PROGRAM_OK(boot_ok), .PAR_ADDR(par_addr), .PAR_PROG(par_prog), .PAR_ERASE(par_erase), .FLASH_REQ(req),
      .FLASH_DONE(done), .STATUS_BYTE(status), .SERIAL_MODE(smode), .ID_OK(id_ok), .BOOT_TOUCHED(touched));
   sfpp_prog_model prog (.busy(busy), .txd(txd), .sclk(sclk), .rxd(rxd));
   always #12.5 mclk = ~mclk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input string what, input logic [55:0] exp, input logic [55:0] seen);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checked %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic put(input logic [7:0] b); // one byte with a random gap
      prog.xfer(b, 150 + int'(rnd() % 32'd200), last);
   endtask
   task automatic idc(input logic [55:0] id); // id check: cmd, 3 addr, size, 7 bytes
      put(`SFPP_CMD_IDCHK);
      put(8'hdf);
      put(8'hff);
      put(8'h0f);
      put(8'h07);
      for (int i = 0; i < 7; i++) put(id[8*i+:8]);
      repeat (8) @(negedge mclk);
   endtask
   // flash answers each request after a short random wait
   always @(negedge mclk) begin
      done <= (dly == 5'h01);
      if (req.prog || req.erase) dly <= 5'h02 + 5'(rnd() % 32'd8);
      else if (dly != 5'h00) dly <= dly - 5'h01;
   end
   // each request seen is matched against the oldest note
   always @(negedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         fails++;
         report_and_stop();
      end
      if (!rst && (req.prog || req.erase)) begin
         e = (exp_q.size() != 0) ? exp_q.pop_front() : '0;
         check("request", 56'(e[33:8]), 56'(req[33:8]));
         if (e.prog) check("data", 56'(e.data), 56'(req.data));
      end
   end
   initial begin
      repeat (2) @(negedge mclk);
      rst = 1'b0;
      for (int k = 0; k < 4; k++) begin // only the last strap set selects serial mode
         @(negedge mclk);
         st = straps[k];
         rst = 1'b1;
         repeat (20) @(negedge mclk);
         rst = 1'b0;
         repeat (4) @(negedge mclk);
         check("serial mode", 56'(k == 3), 56'(smode));
      end
      $display("straps test done");
      sid = 56'({rnd(), rnd()});
      status = 8'(rnd());
      put(`SFPP_CMD_STAT);
      put(8'hff);
      check("status byte", 56'(status), 56'(last));
      repeat (8) @(negedge mclk);
      check("busy", 56'h0, 56'(busy));
      put(`SFPP_CMD_PROG); // refused without id
      put(8'h12);
      put(8'h00);
      put(8'h5a);
      @(negedge mclk);
      blank = 1'b1; // blank flash takes commands without id
      exp_q.push_back({1'b0, 1'b1, 24'h023400, 8'h00});
      put(`SFPP_CMD_ERASE);
      put(8'h34);
      put(8'h02);
      put(`SFPP_CONFIRM);
      repeat (20) @(negedge mclk);
      check("blank notes", 56'h0, 56'(exp_q.size()));
      blank = 1'b0;
      idc(sid ^ 56'h01);
      check("id ok", 56'h0, 56'(id_ok));
      idc(sid);
      check("id ok", 56'h1, 56'(id_ok));
      $display("id test done");
      mid = 8'(rnd());
      hi = 8'(rnd() % 32'd15);
      put(`SFPP_CMD_PROG); // full user page
      put(mid);
      put(hi);
      for (int i = 0; i < 256; i++) begin
         d = 8'(rnd());
         exp_q.push_back({1'b1, 1'b0, hi, mid, 8'(i), d});
         put(d);
      end
      exp_q.push_back({1'b0, 1'b1, hi, mid, 8'h00, 8'h00});
      put(`SFPP_CMD_ERASE);
      put(mid);
      put(hi);
      put(`SFPP_CONFIRM);
      put(`SFPP_CMD_ERASE); // boot erase over serial is dropped
      put(8'he0);
      put(8'h0f);
      put(`SFPP_CONFIRM);
      $display("user area test done");
      repeat (20) @(negedge mclk);
      check("boot touched", 56'h0, 56'(touched));
      par_mode = 1'b1;
      par_addr = 24'h012345; // user area, parallel program
      exp_q.push_back({1'b1, 1'b0, 24'h012345, 8'h00});
      par_prog = 1'b1;
      @(negedge mclk);
      par_prog = 1'b0;
      repeat (20) @(negedge mclk);
      check("user touched", 56'h0, 56'(touched));
      par_addr = 24'h0ff123; // inside the boot window
      exp_q.push_back({1'b0, 1'b1, 24'h0fe000, 8'h00});
      par_erase = 1'b1;
      @(negedge mclk);
      par_erase = 1'b0;
      repeat (40) @(negedge mclk);
      check("boot touched", 56'h1, 56'(touched));
      check("notes left", 56'h0, 56'(exp_q.size()));
      boot_ok = 1'b0; // overwritten boot program ends serial mode
      repeat (2) @(negedge mclk);
      check("serial mode", 56'h0, 56'(smode));
      check("busy", 56'h1, 56'(busy));
      boot_ok = 1'b1;
      $display("parallel test done");
      report_and_stop();
   end
endmodule // test_serial_flash_programming_port
